// ==== logic/gem_pkg.sv ====
// constants for the event interrupt mask block
//
// Behaviour
// - service request enabled: interrupt while bus request is seen
// - lockout change enabled: interrupt on each toggle of lockout status
// - remote change enabled: interrupt on each change of local/remote status
// - address change enabled: interrupt when listen/talk/controller changes
// - upper byte bit 0 selects which mask the lower byte loads
// - port range starts at switch-set base, default 2b8 hex
// - interrupt request goes to jumper-chosen host level only
package gem_pkg;
	localparam logic [9:0] IO_BASE_DEFAULT  = 10'h2b8;
	localparam logic [9:0] MASK_PORT_OFFSET = 10'h000;
	localparam int         MASK_SEL_BIT     = 8;
	// first mask fields
	localparam int         M1_TRIGGER_BIT   = 5;
	localparam int         M1_CLEAR_BIT     = 3;
	// second mask fields
	localparam int         M2_SRQ_BIT       = 6;
	localparam int         M2_LOCKOUT_BIT   = 5;
	localparam int         M2_REMOTE_BIT    = 4;
	localparam int         M2_ADDRESS_BIT   = 3;
	localparam logic [7:0] MASK_RESET       = 8'h00;
	localparam logic       LOCKOUT_RESET    = 1'b0;
	localparam logic       REMOTE_RESET     = 1'b0;
	localparam logic [2:0] ADDR_STATUS_RESET = 3'h0;
	localparam logic [7:0] IRQ_LINES_IDLE   = 8'h00;
	localparam int         IRQ_LEVELS       = 8;
	localparam logic [2:0] IRQ_LEVEL_NONE   = 3'h0;
endpackage : gem_pkg

// ==== logic/gem_event_mask.sv ====
// event interrupt masks, base decode and interrupt level routing
`timescale 1ns/1ns
`default_nettype none

// one status word against its value on the previous edge
module gem_change_detect
#(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] level,
	output logic                  changed
);
	logic [WIDTH-1:0] level_q_r;

	// history held at its reset value until release, so a level
	// already away from it counts as a change on the first edge
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			level_q_r <= RESET_VALUE;
		else
			level_q_r <= level;
	end

	// any bit that differs from the previous edge
	assign changed = (level != level_q_r);
endmodule : gem_change_detect

// one write-only interrupt mask, loaded on its select
module gem_mask_reg
(
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	output logic      [7:0] mask_value
);
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			mask_value <= gem_pkg::MASK_RESET;
		else if (load)
			mask_value <= load_data;
	end
endmodule : gem_mask_reg

// masks, change detection and host line routing
module gem_event_mask
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [9:0]  base_switch,
	input  wire logic [9:0]  io_addr,
	input  wire logic        io_wr,
	input  wire logic [15:0] io_wdata,
	input  wire logic        srq_in,
	input  wire logic        trigger_event,
	input  wire logic        clear_event,
	input  wire logic        lockout_status,
	input  wire logic        remote_status,
	input  wire logic        listen_addressed,
	input  wire logic        talk_addressed,
	input  wire logic        controller_in_charge,
	input  wire logic [2:0]  irq_level_jumper,
	output logic [7:0]       irq_out,
	output logic [7:0]       event_interrupt_enable_first,
	output logic [7:0]       event_interrupt_enable_second
);
	logic [9:0] mask_port_addr;
	logic       mask_wr;
	logic       mask_select_bit;
	logic       load_first;
	logic       load_second;
	logic [2:0] addr_status;
	logic       lockout_changed;
	logic       remote_changed;
	logic       addr_changed;
	logic       service_request_irq_enable;
	logic       lockout_change_irq_enable;
	logic       remote_change_irq_enable;
	logic       address_status_change_irq_enable;
	logic       trigger_irq_enable;
	logic       clear_irq_enable;
	logic       srq_hit;
	logic       lockout_hit;
	logic       remote_hit;
	logic       addr_hit;
	logic       trigger_hit;
	logic       clear_hit;
	logic       irq_req_nxt;
	logic       level_chosen;
	logic [7:0] irq_line_nxt;

	// only the switch-set base is answered
	assign mask_port_addr =
		10'(base_switch + gem_pkg::MASK_PORT_OFFSET);
	assign mask_wr = io_wr
		&& (io_addr == mask_port_addr);
	assign mask_select_bit = io_wdata[gem_pkg::MASK_SEL_BIT];
	assign load_first = mask_wr && !mask_select_bit;
	assign load_second = mask_wr && mask_select_bit;

	gem_mask_reg u_mask_first
	(
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.load       (load_first),
		.load_data  (io_wdata[7:0]),
		.mask_value (event_interrupt_enable_first)
	);

	gem_mask_reg u_mask_second
	(
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.load       (load_second),
		.load_data  (io_wdata[7:0]),
		.mask_value (event_interrupt_enable_second)
	);

	// named enable bits of both masks
	assign service_request_irq_enable =
		event_interrupt_enable_second[gem_pkg::M2_SRQ_BIT];
	assign lockout_change_irq_enable =
		event_interrupt_enable_second[gem_pkg::M2_LOCKOUT_BIT];
	assign remote_change_irq_enable =
		event_interrupt_enable_second[gem_pkg::M2_REMOTE_BIT];
	assign address_status_change_irq_enable =
		event_interrupt_enable_second[gem_pkg::M2_ADDRESS_BIT];
	assign trigger_irq_enable =
		event_interrupt_enable_first[gem_pkg::M1_TRIGGER_BIT];
	assign clear_irq_enable =
		event_interrupt_enable_first[gem_pkg::M1_CLEAR_BIT];

	assign addr_status = {listen_addressed, talk_addressed,
		controller_in_charge};

	// lockout status history
	gem_change_detect
	#(
		.WIDTH       (1),
		.RESET_VALUE (gem_pkg::LOCKOUT_RESET)
	)
	u_lockout_change
	(
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.level    (lockout_status),
		.changed  (lockout_changed)
	);

	// local/remote status history
	gem_change_detect
	#(
		.WIDTH       (1),
		.RESET_VALUE (gem_pkg::REMOTE_RESET)
	)
	u_remote_change
	(
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.level    (remote_status),
		.changed  (remote_changed)
	);

	// listen, talk and controller status history
	gem_change_detect
	#(
		.WIDTH       (3),
		.RESET_VALUE (gem_pkg::ADDR_STATUS_RESET)
	)
	u_addr_change
	(
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.level    (addr_status),
		.changed  (addr_changed)
	);

	// each condition counts only while its enable is set
	assign srq_hit = service_request_irq_enable
		&& srq_in;
	assign lockout_hit = lockout_change_irq_enable
		&& lockout_changed;
	assign remote_hit = remote_change_irq_enable
		&& remote_changed;
	assign addr_hit = address_status_change_irq_enable
		&& addr_changed;
	assign trigger_hit = trigger_irq_enable
		&& trigger_event;
	assign clear_hit = clear_irq_enable
		&& clear_event;

	// no pending latch: a request lasts as long as its cause
	always_comb
	begin
		irq_req_nxt = 1'b0;
		if (srq_hit || lockout_hit)
			irq_req_nxt = 1'b1;
		if (remote_hit || addr_hit)
			irq_req_nxt = 1'b1;
		if (trigger_hit || clear_hit)
			irq_req_nxt = 1'b1;
	end

	// one host line, picked by the jumper; none when no level chosen
	assign level_chosen =
		(irq_level_jumper != gem_pkg::IRQ_LEVEL_NONE);

	always_comb
	begin
		irq_line_nxt = gem_pkg::IRQ_LINES_IDLE;
		irq_line_nxt[irq_level_jumper] = 1'b1;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			irq_out <= gem_pkg::IRQ_LINES_IDLE;
		else if (irq_req_nxt && level_chosen)
			irq_out <= irq_line_nxt;
		else
			irq_out <= gem_pkg::IRQ_LINES_IDLE;
	end
endmodule : gem_event_mask
`default_nettype wire

// ==== verification/gem_event_mask_asserts.sv ====
// port checker for the event interrupt mask
`timescale 1ns/1ns
`default_nettype none
module gem_event_mask_asserts
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [9:0]  base_switch,
	input wire logic [9:0]  io_addr,
	input wire logic        io_wr,
	input wire logic [15:0] io_wdata,
	input wire logic        srq_in,
	input wire logic        trigger_event,
	input wire logic        clear_event,
	input wire logic        lockout_status,
	input wire logic        remote_status,
	input wire logic        listen_addressed,
	input wire logic        talk_addressed,
	input wire logic        controller_in_charge,
	input wire logic [2:0]  irq_level_jumper,
	input wire logic [7:0]  irq_out,
	input wire logic [7:0]  event_interrupt_enable_first,
	input wire logic [7:0]  event_interrupt_enable_second
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire logic [7:0] m = event_interrupt_enable_second;
	wire logic [7:0] f = event_interrupt_enable_first;
	wire logic [2:0] j = irq_level_jumper;
	wire logic [2:0] a = {listen_addressed, talk_addressed,
		controller_in_charge};
	wire logic       hit = io_wr && io_addr == base_switch;
	wire logic       off = !m[6] && !m[5] && !m[4] && !m[3]
		&& !f[5] && !f[3];
	property p_srq;
		m[6] && srq_in && j != 3'h0 |=> irq_out[$past(j)];
	endproperty
	a_srq: assert property (p_srq) else $error("srq irq missing");
	property p_lok;
		m[5] && $changed(lockout_status) && j != 3'h0
			|=> irq_out[$past(j)];
	endproperty
	a_lok: assert property (p_lok) else $error("lockout irq missing");
	property p_rem;
		m[4] && $changed(remote_status) && j != 3'h0
			|=> irq_out[$past(j)];
	endproperty
	a_rem: assert property (p_rem) else $error("remote irq missing");
	property p_adr;
		m[3] && $changed(a) && j != 3'h0 |=> irq_out[$past(j)];
	endproperty
	a_adr: assert property (p_adr) else $error("address irq missing");
	property p_sel1;
		hit && io_wdata[8] |=> m == $past(io_wdata[7:0]);
	endproperty
	a_sel1: assert property (p_sel1) else $error("mask2 not loaded");
	property p_sel0;
		hit && !io_wdata[8] |=> $stable(m);
	endproperty
	a_sel0: assert property (p_sel0) else $error("mask2 overwritten");
	property p_dec;
		io_wr && io_addr != base_switch |=> $stable(m);
	endproperty
	a_dec: assert property (p_dec) else $error("foreign write taken");
	property p_jmp;
		j == 3'h0 |=> irq_out == 8'h00;
	endproperty
	a_jmp: assert property (p_jmp) else $error("irq without level");
	property p_one;
		$onehot0(irq_out) && irq_out[0] == 1'b0;
	endproperty
	a_one: assert property (p_one) else $error("irq lines not single");
	property p_off;
		off |=> irq_out == 8'h00;
	endproperty
	a_off: assert property (p_off) else $error("disabled irq raised");
endmodule : gem_event_mask_asserts
bind gem_event_mask gem_event_mask_asserts u_chk (.*);
`default_nettype wire

// ==== verification/gem_bus_model.sv ====
// far-side bus status model: toggles levels, pulses events
`timescale 1ns/1ns
`default_nettype none
module gem_bus_model
(
	input  wire logic       core_clk,
	input  wire logic [7:0] tgl,
	output var logic [7:0]  st = 8'h00
);
	always @(negedge core_clk) st <= {tgl[7:6], st[5:0] ^ tgl[5:0]};
endmodule : gem_bus_model
`default_nettype wire

// ==== verification/gpib_event_interrupt_mask_test.sv ====
// bench for the event interrupt mask
`timescale 1ns/1ns
`default_nettype none
module gpib_event_interrupt_mask_test;
	logic        core_clk = 1'b0, reset_n = 1'b0, io_wr = 1'b0;
	logic [9:0]  base_switch = 10'h2b8, io_addr = 10'h000;
	logic [15:0] io_wdata = 16'h0000;
	logic [2:0]  irq_level_jumper = 3'h3;
	logic [7:0]  tgl = 8'h00, st, irq_out, event_interrupt_enable_first;
	logic [7:0]  event_interrupt_enable_second;
	wire logic   srq_in, lockout_status, remote_status, listen_addressed;
	wire logic   talk_addressed, controller_in_charge;
	wire logic   trigger_event, clear_event;
	assign {clear_event, trigger_event, controller_in_charge, talk_addressed,
		listen_addressed, remote_status, lockout_status, srq_in} = st;
	int err_count = 0, checks = 0, i;
	always #50 core_clk = ~core_clk;
	gem_event_mask uut
	(
		.core_clk                      (core_clk),
		.reset_n                       (reset_n),
		.base_switch                   (base_switch),
		.io_addr                       (io_addr),
		.io_wr                         (io_wr),
		.io_wdata                      (io_wdata),
		.srq_in                        (srq_in),
		.trigger_event                 (trigger_event),
		.clear_event                   (clear_event),
		.lockout_status                (lockout_status),
		.remote_status                 (remote_status),
		.listen_addressed              (listen_addressed),
		.talk_addressed                (talk_addressed),
		.controller_in_charge          (controller_in_charge),
		.irq_level_jumper              (irq_level_jumper),
		.irq_out                       (irq_out),
		.event_interrupt_enable_first  (event_interrupt_enable_first),
		.event_interrupt_enable_second (event_interrupt_enable_second)
	);
	gem_bus_model bm (.core_clk, .tgl, .st);
	task automatic chk(logic [7:0] s, logic [7:0] e);
		checks++;
		err_count += (s !== e);
		if (s !== e) $display("[ERR] %0t seen %h want %h", $time, s, e);
	endtask : chk
	task automatic wr(logic [9:0] a, logic [15:0] d);
		@(negedge core_clk) {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		@(negedge core_clk) io_wr = 1'b0;
	endtask : wr
	task automatic ev(logic [7:0] t, logic [7:0] a, logic [7:0] b);
		@(negedge core_clk) tgl <= t;
		@(negedge core_clk) tgl <= 8'h00;
		@(negedge core_clk) chk(irq_out, a);
		@(negedge core_clk) chk(irq_out, b);
		$display("%0t event test done", $time);
	endtask : ev
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (6) @(negedge core_clk);
		reset_n = 1'b1;
		chk(event_interrupt_enable_second, 8'h00);
		wr(10'h2b8, 16'h0140);
		chk(event_interrupt_enable_second, 8'h40);
		ev(8'h01, 8'h08, 8'h08);
		ev(8'h01, 8'h00, 8'h00);
		ev(8'h02, 8'h00, 8'h00);
		for (i = 0; i < 5; i++)
		begin
			wr(10'h2b8, 16'h0100 | (16'h0020 >> (i > 2 ? 2 : i)));
			ev(8'h02 << i, 8'h08, 8'h00);
		end
		wr(10'h2b9, 16'h01ff);
		chk(event_interrupt_enable_second, 8'h08);
		wr(10'h2b8, 16'hfe28);
		chk(event_interrupt_enable_first, 8'h28);
		ev(8'h40, 8'h08, 8'h00);
		irq_level_jumper = 3'h5;
		ev(8'h80, 8'h20, 8'h00);
		irq_level_jumper = 3'h0;
		ev(8'h80, 8'h00, 8'h00);
		base_switch = 10'h300;
		wr(10'h300, 16'h0100);
		chk(event_interrupt_enable_second, 8'h00);
		wr(10'h2b8, 16'h0140);
		chk(event_interrupt_enable_second, 8'h00);
		report_and_stop;
	end
endmodule : gpib_event_interrupt_mask_test
`default_nettype wire
